// File: timer_clock_clear.v
// six-channel timer counting clock, edge and clear selection with apb access
//
// Contract
// (RULE1) edge field: 00 rising, 01 falling, 1x both edges.
// (RULE2) prescaler bits 2..0 pick the channel's counting clock.
// (RULE3) each channel picks its clock source on its own.
// (RULE4) channels 0 and 3: codes 000 and 100 never clear.
// (RULE5) code 001 clears on register a match or capture.
// (RULE6) code 010 clears on register b match or capture.
// (RULE7) code 011 or 111 clears on synchronous clear of another channel.
// (RULE8) only channels with their synchro bit set join synchronous clearing.
// (RULE9) channels 0 and 3: 101 clears on c, 110 on d.
// (RULE10) c or d used as buffer never causes a clear.
// (RULE11) channels 1,2,4,5: control bit 7 reads 0, ignores writes.
// (RULE12) channels 1,2,4,5 have only four clear codes.
// (RULE13) codes 000..011 pick internal clock divided by 1, 4, 16, 64.
// (RULE14) codes 100..111 pick external pins a, b, c, d.
// (RULE15) edge field in bits 4..3; both edges halve the period.
// (RULE16) edge select applies only to divide-by-4 and slower.
// (RULE17) phase counting on channels 1,2,4,5 overrides the edge field.
// (RULE18) software changes control only while the counter is stopped.
// (RULE19) pins are synchronised; each chosen edge gives one count pulse.
`include "timer_ccs_map.vh"

module timer_clock_clear #(
    parameter CW = 16
) (
    input wire MCLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire [3:0] EXT_CLK_PIN,
    input wire [5:0] MATCH_A,
    input wire [5:0] MATCH_B,
    input wire [5:0] MATCH_C,
    input wire [5:0] MATCH_D,
    input wire [5:0] PHASE_TICK,
    output reg [5:0] COUNT_EN,
    output reg [5:0] CLEAR
);

    // ==============================
    // state
    reg [7:0] ctrl [0:5];
    reg [5:0] synchro;
    reg [5:0] start;
    reg [3:0] bufcfg;
    reg [5:0] phase;
    reg [3:0] pin_s1;
    reg [3:0] pin_s2;
    reg [3:0] pin_d;
    reg [`PRE_W-1:0] pre;
    reg [31:0] next_rdata;
    reg next_err;

    wire [3:0] pin_rise;
    wire [3:0] pin_fall;
    wire [2:0] int_rise;
    wire [2:0] int_fall;
    wire [5:0] tick;
    wire [5:0] own_clr;
    wire [5:0] clr;
    wire [CW-1:0] count [0:5];
    wire sync_any;
    wire wr;
    wire [2:0] idx;
    wire in_ctrl;
    wire in_cnt;
    integer i;

    // ==============================
    // pin synchronisers and edge detect
    always @(posedge MCLK) begin
        if (RST) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_d <= 4'h0;
        end else begin
            pin_s1 <= EXT_CLK_PIN; // (RULE19)
            pin_s2 <= pin_s1; // (RULE19)
            pin_d <= pin_s2;
        end
    end

    // reset level low, so a pin held high at release gives one rising edge
    assign pin_rise = pin_s2 & ~pin_d; // (RULE19)
    assign pin_fall = ~pin_s2 & pin_d; // (RULE19)

    // ==============================
    // shared prescaler
    always @(posedge MCLK) begin
        if (RST)
            pre <= {`PRE_W{1'b0}};
        else
            pre <= pre + {{(`PRE_W-1){1'b0}}, 1'b1};
    end

    // divided clocks as square waves: a rise mid-period, a fall at wrap
    assign int_rise[0] = (pre[1:0] == `RISE4); // (RULE13)
    assign int_fall[0] = (pre[1:0] == `FALL4); // (RULE13)
    assign int_rise[1] = (pre[3:0] == `RISE16); // (RULE13)
    assign int_fall[1] = (pre[3:0] == `FALL16); // (RULE13)
    assign int_rise[2] = (pre[5:0] == `RISE64); // (RULE13)
    assign int_fall[2] = (pre[5:0] == `FALL64); // (RULE13)

    // ==============================
    // channels
    assign sync_any = |own_clr; // (RULE7) (RULE8)

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : ch
            channel_slice #(
                .FOUR_GR((g == 0) || (g == 3)),
                .HAS_PHASE((g != 0) && (g != 3)),
                .CW(CW)
            ) u_slice (
                .clk(MCLK),
                .rst(RST),
                .ctrl(ctrl[g]),
                .run(start[g]),
                .sync_on(synchro[g]),
                .buf_c(g == 0 ? bufcfg[`BUF_C0] :
                    (g == 3 ? bufcfg[`BUF_C3] : 1'b0)),
                .buf_d(g == 0 ? bufcfg[`BUF_D0] :
                    (g == 3 ? bufcfg[`BUF_D3] : 1'b0)),
                .phase_on(phase[g]),
                .phase_tick(PHASE_TICK[g]),
                .int_rise(int_rise),
                .int_fall(int_fall),
                .pin_rise(pin_rise),
                .pin_fall(pin_fall),
                .evt_a(MATCH_A[g]),
                .evt_b(MATCH_B[g]),
                .evt_c(MATCH_C[g]),
                .evt_d(MATCH_D[g]),
                .sync_clr_in(sync_any),
                .count(count[g]),
                .tick(tick[g]),
                .own_clr(own_clr[g]),
                .clr(clr[g])
            );
        end
    endgenerate

    // ==============================
    // registered outputs
    always @(posedge MCLK) begin
        if (RST) begin
            COUNT_EN <= 6'h00;
            CLEAR <= 6'h00;
        end else begin
            COUNT_EN <= tick & ~clr;
            CLEAR <= clr;
        end
    end

    // ==============================
    // apb decode, one wait state
    assign wr = PSEL & PENABLE & PREADY & PWRITE;
    assign idx = PADDR[4:2];
    assign in_ctrl = (PADDR >= `OFS_CTRL_BASE) && (PADDR <= `OFS_CTRL_LAST);
    assign in_cnt = (PADDR >= `OFS_CNT_BASE) && (PADDR <= `OFS_CNT_LAST);

    always @(posedge MCLK) begin
        if (RST)
            PREADY <= 1'b0;
        else
            PREADY <= PSEL & PENABLE & ~PREADY;
    end

    // stopping the counter first is left to software
    always @(posedge MCLK) begin // (RULE18)
        if (RST) begin
            for (i = 0; i < 6; i = i + 1)
                ctrl[i] <= `CTRL_RESET;
            synchro <= 6'h00;
            start <= 6'h00;
            bufcfg <= 4'h0;
            phase <= 6'h00;
        end else if (wr && PADDR[1:0] == 2'h0) begin
            if (in_ctrl) begin
                if (idx == 3'h0 || idx == 3'h3)
                    ctrl[idx] <= PWDATA[7:0];
                else
                    ctrl[idx] <= PWDATA[7:0] & `CTRL_MASK_TWO_GR; // (RULE11)
            end
            case (PADDR)
                `OFS_SYNCHRO: synchro <= PWDATA[5:0]; // (RULE8)
                `OFS_START: start <= PWDATA[5:0];
                `OFS_BUFCFG: bufcfg <= PWDATA[3:0];
                `OFS_PHASE: phase <= PWDATA[5:0] & 6'h36; // (RULE17)
                default: begin
                end
            endcase
        end
    end

    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        if (PADDR[1:0] != 2'h0) begin
            next_err = 1'b1;
        end else if (in_ctrl) begin
            next_rdata[7:0] = ctrl[idx];
        end else if (in_cnt) begin
            next_rdata[CW-1:0] = count[idx];
            next_err = PWRITE;
        end else begin
            case (PADDR)
                `OFS_SYNCHRO: next_rdata[5:0] = synchro;
                `OFS_START: next_rdata[5:0] = start;
                `OFS_BUFCFG: next_rdata[3:0] = bufcfg;
                `OFS_PHASE: next_rdata[5:0] = phase;
                default: next_err = 1'b1;
            endcase
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else if (PSEL & PENABLE & ~PREADY) begin
            PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
            PSLVERR <= next_err;
        end else begin
            PSLVERR <= 1'b0;
        end
    end

endmodule // timer_clock_clear

// File: timer_ccs_map.vh
// register map, field positions and prescaler constants of the timer
`ifndef TIMER_CCS_MAP_VH
`define TIMER_CCS_MAP_VH

// ==============================
// register byte offsets
`define OFS_CTRL_BASE 8'h00
`define OFS_CTRL_LAST 8'h14
`define OFS_SYNCHRO 8'h18
`define OFS_START 8'h1C
`define OFS_BUFCFG 8'h20
`define OFS_PHASE 8'h24
`define OFS_CNT_BASE 8'h40
`define OFS_CNT_LAST 8'h54

// ==============================
// counter_control fields
`define CCL_MSB 7
`define CCL_LSB 5
`define EDG_MSB 4
`define EDG_LSB 3
`define PSC_MSB 2
`define PSC_LSB 0
`define CTRL_RESET 8'h00
`define CTRL_MASK_TWO_GR 8'h7F

// ==============================
// clear-source codes
`define CCL_OFF 3'h0
`define CCL_GRA 3'h1
`define CCL_GRB 3'h2
`define CCL_SYNC 3'h3
`define CCL_OFF2 3'h4
`define CCL_GRC 3'h5
`define CCL_GRD 3'h6
`define CCL_SYNC2 3'h7

// ==============================
// prescaler codes
`define PSC_DIV1 3'h0
`define PSC_DIV4 3'h1
`define PSC_DIV16 3'h2
`define PSC_DIV64 3'h3
`define PSC_PIN_A 3'h4
`define PSC_PIN_B 3'h5
`define PSC_PIN_C 3'h6
`define PSC_PIN_D 3'h7

// ==============================
// divided clock edge points of the prescaler count
`define PRE_W 6
`define RISE4 2'h1
`define FALL4 2'h3
`define RISE16 4'h7
`define FALL16 4'hF
`define RISE64 6'h1F
`define FALL64 6'h3F

// ==============================
// buffer config bit positions
`define BUF_C0 0
`define BUF_D0 1
`define BUF_C3 2
`define BUF_D3 3

`endif

// File: channel_slice.v
// one timer channel: count clock select, edge select, clear select, counter
`include "timer_ccs_map.vh"

module channel_slice #(
    parameter FOUR_GR = 0,
    parameter HAS_PHASE = 0,
    parameter CW = 16
) (
    input wire clk,
    input wire rst,
    input wire [7:0] ctrl,
    input wire run,
    input wire sync_on,
    input wire buf_c,
    input wire buf_d,
    input wire phase_on,
    input wire phase_tick,
    input wire [2:0] int_rise,
    input wire [2:0] int_fall,
    input wire [3:0] pin_rise,
    input wire [3:0] pin_fall,
    input wire evt_a,
    input wire evt_b,
    input wire evt_c,
    input wire evt_d,
    input wire sync_clr_in,
    output reg [CW-1:0] count,
    output wire tick,
    output wire own_clr,
    output wire clr
);

    wire [2:0] psc;
    wire [1:0] edg;
    wire [2:0] ccl;
    reg src;
    reg own;

    assign psc = ctrl[`PSC_MSB:`PSC_LSB];
    assign edg = ctrl[`EDG_MSB:`EDG_LSB];
    assign ccl = ctrl[`CCL_MSB:`CCL_LSB];

    // ==============================
    // edge pick
    function pick;
        input r;
        input f;
        input [1:0] e;
        begin
            if (e[1])
                pick = r | f; // (RULE1) (RULE15)
            else if (e[0])
                pick = f; // (RULE1)
            else
                pick = r; // (RULE1)
        end
    endfunction

    // ==============================
    // count source
    always @* begin
        case (psc) // (RULE2) (RULE3)
            `PSC_DIV1: src = 1'b1; // (RULE13) (RULE16)
            `PSC_DIV4: src = pick(int_rise[0], int_fall[0], edg); // (RULE13)
            `PSC_DIV16: src = pick(int_rise[1], int_fall[1], edg); // (RULE13)
            `PSC_DIV64: src = pick(int_rise[2], int_fall[2], edg); // (RULE13)
            `PSC_PIN_A: src = pick(pin_rise[0], pin_fall[0], edg); // (RULE14)
            `PSC_PIN_B: src = pick(pin_rise[1], pin_fall[1], edg); // (RULE14)
            `PSC_PIN_C: src = pick(pin_rise[2], pin_fall[2], edg); // (RULE14)
            `PSC_PIN_D: src = pick(pin_rise[3], pin_fall[3], edg); // (RULE14)
            default: src = 1'b0;
        endcase
    end

    // phase counting overrides the edge field
    assign tick = run & ((HAS_PHASE != 0 && phase_on) ? phase_tick : src); // (RULE17)

    // ==============================
    // clear source
    always @* begin
        case (ccl)
            `CCL_GRA: own = evt_a; // (RULE5)
            `CCL_GRB: own = evt_b; // (RULE6)
            // buffer use suppresses match and capture on c and d
            `CCL_GRC: own = (FOUR_GR != 0) & evt_c & ~buf_c; // (RULE9) (RULE10)
            `CCL_GRD: own = (FOUR_GR != 0) & evt_d & ~buf_d; // (RULE9) (RULE10)
            default: own = 1'b0; // (RULE4) (RULE12)
        endcase
    end

    assign own_clr = own & sync_on; // (RULE8)
    // 011 and 111 share the low bits; bit 7 is zero on two-register channels
    assign clr = own | ((ccl[1:0] == 2'b11) & sync_on & sync_clr_in); // (RULE7) (RULE8)

    // ==============================
    // counter, clear wins over count
    always @(posedge clk) begin
        if (rst)
            count <= {CW{1'b0}};
        else if (clr)
            count <= {CW{1'b0}};
        else if (tick)
            count <= count + {{(CW-1){1'b0}}, 1'b1};
    end

endmodule // channel_slice

// File: timer_clock_clear_props.sv
// checker of apb timing, readback and clear/count outputs of the timer
module timer_clock_clear_props (
    input wire MCLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire [5:0] MATCH_A,
    input wire [5:0] MATCH_B,
    input wire [5:0] MATCH_C,
    input wire [5:0] MATCH_D,
    input wire [5:0] COUNT_EN,
    input wire [5:0] CLEAR
);
    // ==============================
    // assertions
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    a_ready_one_wait: assert property ($rose(PENABLE) && PSEL |->
        !PREADY ##1 PREADY) else $error("ready not in second access cycle");
    a_ready_one_cycle: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access phase");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_counter_read_only: assert property (PREADY && PWRITE && PADDR[6]
        |-> PSLVERR) else $error("counter write accepted");
    a_top_bit_zero: assert property (PREADY && !PWRITE && PADDR < 8'h18
        && PADDR != 8'h00 && PADDR != 8'h0C |-> !PRDATA[7])
        else $error("bit 7 set on two-register channel");
    a_ctrl_width: assert property (PREADY && !PWRITE && PADDR < 8'h18
        |-> PRDATA[31:8] == 24'h0) else $error("control upper bits set");
    a_write_data_zero: assert property (PREADY && PWRITE |-> PRDATA == 32'h0)
        else $error("read data on write");
    a_clear_has_cause: assert property (CLEAR != 6'h00 |->
        $past(|{MATCH_A, MATCH_B, MATCH_C, MATCH_D}))
        else $error("clear without an event");
    a_clear_beats_count: assert property ((CLEAR & COUNT_EN) == 6'h00)
        else $error("count and clear together");
    // ==============================
    // covers
    c_refused: cover property (PREADY && PSLVERR);
    c_cleared: cover property (CLEAR != 6'h00);
    c_counted: cover property (COUNT_EN != 6'h00);
endmodule // timer_clock_clear_props

bind timer_clock_clear timer_clock_clear_props timer_clock_clear_props_i (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MATCH_A(MATCH_A), .MATCH_B(MATCH_B),
    .MATCH_C(MATCH_C), .MATCH_D(MATCH_D), .COUNT_EN(COUNT_EN),
    .CLEAR(CLEAR));

// File: test_timer_clock_clear.sv
// self-checking bench of the timer clock and clear selection
`define CHK(n, x, y) begin checks++; if ((x) !== (y)) begin errors++; \
    $display("[FAIL] %s exp %0h got %0h", n, y, x); end end
module test_timer_clock_clear;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY;
    logic PSLVERR, e;
    logic [7:0] PADDR = 8'h00, cyc = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, q;
    logic [3:0] EXT_CLK_PIN = 4'h0, bf;
    logic [5:0] PHASE_TICK = 6'h00, COUNT_EN, CLEAR;
    logic [23:0] m = 24'h0; // events d, c, b, a
    int errors = 0, checks = 0, n0, n1, o, rp, rg, sy, ch, c, s, p, g, i;
    int chs[4] = '{0, 1, 3, 5};
    timer_clock_clear timer_clock_clear_i (.MCLK(MCLK), .RST(RST),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .EXT_CLK_PIN(EXT_CLK_PIN), .MATCH_A(m[5:0]),
        .MATCH_B(m[11:6]), .MATCH_C(m[17:12]), .MATCH_D(m[23:18]),
        .PHASE_TICK(PHASE_TICK), .COUNT_EN(COUNT_EN), .CLEAR(CLEAR));
    initial forever #5 MCLK = ~MCLK;
    // pins a..d periods 4, 8, 16, 32; phase ticks must be ignored
    always @(posedge MCLK) begin
        cyc <= cyc + 8'h01;
        EXT_CLK_PIN <= cyc[4:1];
        PHASE_TICK <= 6'($urandom);
    end
    // ==============================
    // tasks and expectations
    task print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        // ready is read at the edge itself, before the design updates it
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 9);
        if (PREADY !== 1'b1) begin
            errors++;
            print_verdict;
        end
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
    endtask
    function logic exp_clr(int ch, logic [2:0] c, int s, logic [3:0] bf,
        logic sy);
        logic four;
        four = ch == 0 || ch == 3;
        if (!four) c[2] = 1'b0;
        case (s)
            0: return c == 3'h1;
            1: return c == 3'h2;
            2: return four && c == 3'h5 && !bf[ch == 3 ? 2 : 0];
            3: return four && c == 3'h6 && !bf[ch == 3 ? 3 : 1];
            default: return sy && c[1:0] == 2'h3;
        endcase
    endfunction
    // window of 128 cycles holds whole periods of every source
    function int ecnt(int p, int g);
        if (p == 0) return 128;
        return (128 / (p < 4 ? 1 << (2 * p) : 4 << (p - 4))) << g[1];
    endfunction
    // ==============================
    // main sequence
    initial begin
        void'($urandom(89988));
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        for (i = 0; i < 6; i++) begin
            apb(0, 8'(i * 4), 0);
            `CHK("ctrl reset", q, 32'h0)
            apb(1, 8'(i * 4), 32'hFF);
            apb(0, 8'(i * 4), 0);
            `CHK("ctrl rw", q, (i == 0 || i == 3) ? 32'hFF : 32'h7F)
            apb(1, 8'(i * 4), 0);
        end
        apb(1, 8'h30, 0);
        `CHK("unmapped", e, 1'b1)
        apb(0, 8'h01, 0);
        `CHK("misaligned", e, 1'b1)
        apb(0, 8'h40, 0);
        `CHK("counter read", e, 1'b0)
        apb(1, 8'h44, 0);
        `CHK("counter write", e, 1'b1)
        $display("test registers done");
        apb(1, 8'h08, 32'h20);
        for (i = 0; i < 4; i++) for (c = 0; c < 8; c++) begin
            ch = chs[i];
            bf = 4'($urandom);
            sy = $urandom % 2;
            apb(1, 8'(ch * 4), 32'(c << 5 | $urandom % 32));
            apb(1, 8'h18, 32'(4 | sy << ch));
            apb(1, 8'h20, 32'(bf));
            for (s = 0; s < 5; s++) begin
                m <= 24'h1 << (s == 4 ? 2 : s * 6 + ch);
                @(posedge MCLK);
                m <= 24'h0;
                #1;
                `CHK("clear", CLEAR[ch], exp_clr(ch, c, s, bf, sy))
                @(posedge MCLK);
            end
        end
        $display("test clear sources done");
        for (p = 0; p < 8; p++) for (g = 0; g < 4; g++) begin
            o = 1 + $urandom % 5;
            rp = $urandom % 8;
            rg = $urandom % 4;
            apb(1, 8'h00, 32'(g << 3 | p));
            apb(1, 8'(o * 4), 32'(rg << 3 | rp));
            apb(1, 8'h1C, 32'(1 | 1 << o));
            repeat (8) @(posedge MCLK);
            n0 = 0;
            n1 = 0;
            repeat (128) begin
                @(posedge MCLK);
                #1;
                n0 += COUNT_EN[0] === 1'b1;
                n1 += COUNT_EN[o] === 1'b1;
            end
            `CHK("count ch0", n0, ecnt(p, g))
            `CHK("count other", n1, ecnt(rp, rg))
            @(posedge MCLK);
            // control is only rewritten once both counters are stopped
            apb(1, 8'h1C, 0);
        end
        $display("test counting clocks done");
        print_verdict;
    end
endmodule // test_timer_clock_clear
